// File: logic/vsf_defines.vh
// Constants for the vibration sample filter and offset block
`ifndef VSF_DEFINES_VH
`define VSF_DEFINES_VH

// ***************************************************************
// Register offsets (byte addresses of the low byte)
// ***************************************************************
`define VSF_ADDR_TRIM_X 7'h02
`define VSF_ADDR_TRIM_Y 7'h04
`define VSF_ADDR_TRIM_Z 7'h06
`define VSF_ADDR_BUF_X 7'h14
`define VSF_ADDR_CAPTURE_CONTROL 7'h1C
`define VSF_ADDR_AVG_EXP 7'h38
`define VSF_ADDR_DIAG 7'h3C
`define VSF_ADDR_GLOBAL_COMMAND 7'h3E
`define VSF_ADDR_FLASH_WRITE_COUNTER 7'h50
`define VSF_ADDR_LOT_FIRST 7'h52
`define VSF_ADDR_LOT_SECOND 7'h54
`define VSF_ADDR_PROD 7'h56
`define VSF_ADDR_SERIAL 7'h58

// ***************************************************************
// Field positions and reset values
// ***************************************************************
`define VSF_CAPT_BP_BIT 7
`define VSF_CMD_NULL_BIT 0
`define VSF_CMD_CLR_BIT 4
`define VSF_CMD_TEST_BIT 5
`define VSF_CMD_CAPT_BIT 11
`define VSF_DIAG_SPI_BIT 3
`define VSF_DIAG_SUM_BIT 6
`define VSF_AVG_EXP_MAX 4'h0A
`define VSF_RST_TRIM 16'h0000
`define VSF_RST_CAPTURE_CONTROL 16'h0000
`define VSF_RST_AVG_EXP 4'h0

// ***************************************************************
// Filter and timing constants
// ***************************************************************
`define VSF_NULL_LAST 16'hFFFF
`define VSF_LP_COEF 16'h4A00
`define VSF_HP_COEF 16'h18D5
`define VSF_FRAME_BITS 5'h10
`define VSF_CLK_PERIOD_NS 100
`define VSF_FLASH_TEST_US 10500
`define VSF_FLASH_TEST_CYC \
   ((`VSF_FLASH_TEST_US * 1000 + `VSF_CLK_PERIOD_NS - 1) / `VSF_CLK_PERIOD_NS)

`endif

// File: logic/vsf_top.v
// Vibration sample filter, offset trim and command engine with SPI port
//
// How it works
// - Averaging exponent field sets 2^D averages
// - Averager decimates by 2^D, D up to ten
// - Capture control bit seven enables band-pass
// - Band-pass is second-order low then high-pass
// - Band-pass runs at decimated rate, corners scale
// - Per-axis signed sixteen-bit trim register
// - Trim adds to axis data, positive raises
// - Autonull averages 65536 samples, negates, flashes
// - Command bit five runs flash checksum test
// - Read-only counter counts flash write cycles
// - Read-only lot, serial and product words
// - Start-up sequence ends in manual capture mode
// - Reads pipelined: answer comes next frame
// - Checksum failure flag sticky until cleared
`timescale 1ns/1ps
`include "vsf_defines.vh"

module vsf_top #(
   parameter [31:0] TEST_CYCLES = `VSF_FLASH_TEST_CYC,
   parameter [15:0] LOT_FIRST = 16'h1111, // Arbitrary value
   parameter [15:0] LOT_SECOND = 16'h2222, // Arbitrary value
   parameter [15:0] PROD_CODE = 16'h0A5C, // Arbitrary value
   parameter [15:0] SERIAL = 16'h0123 // Arbitrary value
)
(
   input wire ref_clk,
   input wire sys_rst,
   input wire spi_cs_n,
   input wire spi_sclk,
   input wire spi_mosi,
   output reg spi_miso,
   input wire sample_valid,
   input wire [15:0] sample_x,
   input wire [15:0] sample_y,
   input wire [15:0] sample_z,
   input wire [15:0] buf_data,
   output reg buf_rd,
   output reg capture_start,
   output reg capture_manual,
   output reg busy,
   output reg filt_valid,
   output wire [15:0] filt_x,
   output wire [15:0] filt_y,
   output wire [15:0] filt_z
);

   // ************************************************************
   // State codes
   // ************************************************************
   localparam [4:0] ST_BOOT = 5'b00001;
   localparam [4:0] ST_IDLE = 5'b00010;
   localparam [4:0] ST_NULL = 5'b00100;
   localparam [4:0] ST_FLASH = 5'b01000;
   localparam [4:0] ST_TEST = 5'b10000;

   // One-pole step y + k*(x - y), k in Q15; result stays between y and x
   function [15:0] vsf_pole;
      input [15:0] y;
      input [15:0] x;
      input [15:0] k;
      reg signed [16:0] d;
      reg signed [33:0] p;
      begin
         d = $signed({x[15], x}) - $signed({y[15], y});
         p = d * $signed({1'b0, k});
         vsf_pole = y + p[30:15];
      end
   endfunction

   // ************************************************************
   // SPI slave, mode 3, pins sampled as synchronous levels
   // ************************************************************
   reg sclk_d;
   reg cs_d;
   reg [15:0] shift_in;
   reg [15:0] shift_out;
   reg [4:0] bit_cnt;
   reg frm_v;
   reg frm_bad;
   reg [15:0] frm_w;
   reg [15:0] rd_resp;
   reg [15:0] rd_mux;
   wire cs_fall = cs_d & ~spi_cs_n;
   wire cs_rise = ~cs_d & spi_cs_n;
   wire sclk_rise = ~sclk_d & spi_sclk & ~spi_cs_n;
   wire sclk_fall = sclk_d & ~spi_sclk & ~spi_cs_n;
   wire frm_wr = frm_v & frm_w[15];
   wire frm_rd = frm_v & ~frm_w[15];
   wire [6:0] frm_addr = frm_w[14:8];
   wire [7:0] frm_dat = frm_w[7:0];

   // Frame capture; a frame is taken only when the 5-bit count of arrived bits, modulo 32, is 16
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         sclk_d <= 1'b1;
         cs_d <= 1'b1;
         shift_in <= 16'h0000;
         shift_out <= 16'h0000;
         bit_cnt <= 5'h00;
         frm_v <= 1'b0;
         frm_bad <= 1'b0;
         frm_w <= 16'h0000;
         spi_miso <= 1'b0;
      end
      else
      begin
         sclk_d <= spi_sclk;
         cs_d <= spi_cs_n;
         frm_v <= cs_rise & (bit_cnt == `VSF_FRAME_BITS);
         frm_bad <= cs_rise & (bit_cnt != `VSF_FRAME_BITS);
         if (cs_rise)
            frm_w <= shift_in;
         if (cs_fall)
         begin
            shift_out <= rd_resp;
            spi_miso <= rd_resp[15];
            bit_cnt <= 5'h00;
         end
         else if (sclk_rise)
         begin
            shift_in <= {shift_in[14:0], spi_mosi};
            bit_cnt <= bit_cnt + 5'h01;
         end
         else if (sclk_fall)
         begin
            // Mode 3: each falling edge presents the bit sampled next rise
            shift_out <= {shift_out[14:0], 1'b0};
            spi_miso <= shift_out[15];
         end
      end
   end

   // ************************************************************
   // Register file and command engine
   // ************************************************************
   reg [4:0] state;
   reg [4:0] next_state;
   reg [47:0] trim_all;
   reg [15:0] capture_control;
   reg [3:0] avg_exp;
   reg [15:0] diag;
   reg [15:0] flash_write_counter;
   reg [47:0] flash_img;
   reg [15:0] flash_sum;
   reg [15:0] null_cnt;
   reg [31:0] test_cnt;
   wire [47:0] null_trim;
   wire [15:0] cmd_word = {frm_dat, 8'h00};
   wire cmd_hi = frm_wr & (frm_addr == (`VSF_ADDR_GLOBAL_COMMAND | 7'h01));
   wire cmd_lo = frm_wr & (frm_addr == `VSF_ADDR_GLOBAL_COMMAND);
   wire idle = (state == ST_IDLE);
   wire go_null = cmd_lo & frm_dat[`VSF_CMD_NULL_BIT] & idle;
   wire go_test = cmd_lo & frm_dat[`VSF_CMD_TEST_BIT] & idle;
   wire go_clr = cmd_lo & frm_dat[`VSF_CMD_CLR_BIT];
   wire go_capt = cmd_hi & cmd_word[`VSF_CMD_CAPT_BIT] & idle;
   wire null_end = (state == ST_NULL) & sample_valid &
      (null_cnt == `VSF_NULL_LAST);
   wire test_end = (state == ST_TEST) & (test_cnt >= TEST_CYCLES - 32'd1);
   wire [15:0] img_check = flash_img[15:0] + flash_img[31:16] +
      flash_img[47:32];
   wire sum_fail = test_end & (img_check != flash_sum);

   // Next state of the command engine
   always @*
   begin
      next_state = state;
      case (state)
         ST_BOOT: next_state = ST_IDLE;
         ST_IDLE:
         begin
            if (go_null)
               next_state = ST_NULL;
            else if (go_test)
               next_state = ST_TEST;
         end
         ST_NULL:
         begin
            if (null_end)
               next_state = ST_FLASH;
         end
         ST_FLASH: next_state = ST_IDLE;
         ST_TEST:
         begin
            if (test_end)
               next_state = ST_IDLE;
         end
         default: next_state = ST_BOOT;
      endcase
   end

   // Register writes, autonull load, flash image and counters
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state <= ST_BOOT;
         trim_all <= {3{`VSF_RST_TRIM}};
         capture_control <= `VSF_RST_CAPTURE_CONTROL;
         avg_exp <= `VSF_RST_AVG_EXP;
         diag <= 16'h0000;
         flash_write_counter <= 16'h0000;
         flash_img <= 48'h0000_0000_0000;
         flash_sum <= 16'h0000;
         null_cnt <= 16'h0000;
         test_cnt <= 32'h0000_0000;
         busy <= 1'b1;
         capture_manual <= 1'b0;
         capture_start <= 1'b0;
      end
      else
      begin
         state <= next_state;
         busy <= (next_state != ST_IDLE);
         capture_start <= go_capt;
         if (state == ST_BOOT)
            capture_manual <= 1'b1;
         // Byte writes: even address low byte, odd address high byte
         if (frm_wr)
         begin
            case (frm_addr)
               `VSF_ADDR_TRIM_X: trim_all[7:0] <= frm_dat;
               `VSF_ADDR_TRIM_X | 7'h01: trim_all[15:8] <= frm_dat;
               `VSF_ADDR_TRIM_Y: trim_all[23:16] <= frm_dat;
               `VSF_ADDR_TRIM_Y | 7'h01: trim_all[31:24] <= frm_dat;
               `VSF_ADDR_TRIM_Z: trim_all[39:32] <= frm_dat;
               `VSF_ADDR_TRIM_Z | 7'h01: trim_all[47:40] <= frm_dat;
               `VSF_ADDR_CAPTURE_CONTROL: capture_control[7:0] <= frm_dat;
               `VSF_ADDR_CAPTURE_CONTROL | 7'h01: capture_control[15:8] <= frm_dat;
               `VSF_ADDR_AVG_EXP: avg_exp <= frm_dat[3:0];
               default: ;
            endcase
         end
         // Autonull sample count; the sums live in the axis loop
         if (go_null)
            null_cnt <= 16'h0000;
         else if ((state == ST_NULL) & sample_valid)
            null_cnt <= null_cnt + 16'h0001;
         // Flash update: new trims land in registers and image together
         if (state == ST_FLASH)
         begin
            trim_all <= null_trim;
            flash_img <= null_trim;
            flash_sum <= null_trim[15:0] + null_trim[31:16] +
               null_trim[47:32];
            flash_write_counter <= flash_write_counter + 16'h0001;
         end
         if (go_test)
            test_cnt <= 32'h0000_0000;
         else if (state == ST_TEST)
            test_cnt <= test_cnt + 32'h0000_0001;
         // Sticky flags: a setting event wins over a clear
         if (go_clr)
            diag <= 16'h0000;
         if (sum_fail)
            diag[`VSF_DIAG_SUM_BIT] <= 1'b1;
         if (frm_bad)
            diag[`VSF_DIAG_SPI_BIT] <= 1'b1;
      end
   end

   // Read data selection, address low bit ignored
   always @*
   begin
      case ({frm_addr[6:1], 1'b0})
         `VSF_ADDR_TRIM_X: rd_mux = trim_all[15:0];
         `VSF_ADDR_TRIM_Y: rd_mux = trim_all[31:16];
         `VSF_ADDR_TRIM_Z: rd_mux = trim_all[47:32];
         `VSF_ADDR_BUF_X: rd_mux = buf_data;
         `VSF_ADDR_CAPTURE_CONTROL: rd_mux = capture_control;
         `VSF_ADDR_AVG_EXP: rd_mux = {12'h000, avg_exp};
         `VSF_ADDR_DIAG: rd_mux = diag;
         `VSF_ADDR_FLASH_WRITE_COUNTER: rd_mux = flash_write_counter;
         `VSF_ADDR_LOT_FIRST: rd_mux = LOT_FIRST;
         `VSF_ADDR_LOT_SECOND: rd_mux = LOT_SECOND;
         `VSF_ADDR_PROD: rd_mux = PROD_CODE;
         `VSF_ADDR_SERIAL: rd_mux = SERIAL;
         default: rd_mux = 16'h0000;
      endcase
   end

   // Answer held for the next frame; buffer pops on each buffer read
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         rd_resp <= 16'h0000;
         buf_rd <= 1'b0;
      end
      else
      begin
         buf_rd <= frm_rd & ({frm_addr[6:1], 1'b0} == `VSF_ADDR_BUF_X);
         if (frm_rd)
            rd_resp <= rd_mux;
      end
   end

   // ************************************************************
   // Averaging and decimation control shared by the axes
   // ************************************************************
   reg [9:0] averaging_exponent;
   reg avg_v;
   wire [3:0] dexp = (avg_exp > `VSF_AVG_EXP_MAX) ? `VSF_AVG_EXP_MAX : avg_exp;
   wire [10:0] blk_len = 11'h001 << dexp;
   wire blk_end = sample_valid & ({1'b0, averaging_exponent} == blk_len - 11'h001);
   wire bp_en = capture_control[`VSF_CAPT_BP_BIT];
   wire [47:0] raw_all = {sample_z, sample_y, sample_x};

   // Block counter; a new exponent takes effect at once, even part-way through a block
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         averaging_exponent <= 10'h000;
         avg_v <= 1'b0;
         filt_valid <= 1'b0;
      end
      else
      begin
         avg_v <= blk_end;
         filt_valid <= avg_v;
         if (blk_end)
            averaging_exponent <= 10'h000;
         else if (sample_valid)
            averaging_exponent <= averaging_exponent + 10'h001;
      end
   end

   // ************************************************************
   // Per-axis trim, averager, band-pass and autonull sum
   // ************************************************************
   genvar ax;
   generate
      for (ax = 0; ax < 3; ax = ax + 1)
      begin : g_axis
         wire [15:0] raw = raw_all[16*ax +: 16];
         wire [15:0] trim = trim_all[16*ax +: 16];
         wire signed [16:0] tsum = $signed({raw[15], raw}) +
            $signed({trim[15], trim});
         // Saturate so a large trim cannot wrap the sign
         wire [15:0] trimmed = (tsum[16] != tsum[15]) ?
            {tsum[16], {15{~tsum[16]}}} : tsum[15:0];
         reg signed [25:0] acc;
         wire signed [25:0] acc_next = acc + $signed({{10{trimmed[15]}},
            trimmed});
         wire signed [25:0] mean = acc_next >>> dexp;
         reg [15:0] avg_val;
         reg [15:0] lp1;
         reg [15:0] lp2;
         reg [15:0] hpa;
         reg [15:0] hpb;
         reg [15:0] out_val;
         reg signed [31:0] null_acc;
         // Band-pass chain: two low-pass poles, then two high-pass poles
         wire [15:0] n1 = vsf_pole(lp1, avg_val, `VSF_LP_COEF);
         wire [15:0] n2 = vsf_pole(lp2, n1, `VSF_LP_COEF);
         wire [15:0] na = vsf_pole(hpa, n2, `VSF_HP_COEF);
         wire [15:0] h1 = n2 - na;
         wire [15:0] nb = vsf_pole(hpb, h1, `VSF_HP_COEF);
         wire [15:0] h2 = h1 - nb;
         wire [31:0] null_neg = -null_acc;

         assign null_trim[16*ax +: 16] = null_neg[31:16];

         // Filter state; band-pass steps once per decimated sample
         always @(posedge ref_clk)
         begin
            if (sys_rst)
            begin
               acc <= 26'sd0;
               avg_val <= 16'h0000;
               lp1 <= 16'h0000;
               lp2 <= 16'h0000;
               hpa <= 16'h0000;
               hpb <= 16'h0000;
               out_val <= 16'h0000;
               null_acc <= 32'sd0;
            end
            else
            begin
               if (blk_end)
               begin
                  acc <= 26'sd0;
                  avg_val <= mean[15:0];
               end
               else if (sample_valid)
                  acc <= acc_next;
               if (avg_v)
               begin
                  lp1 <= n1;
                  lp2 <= n2;
                  hpa <= na;
                  hpb <= nb;
                  out_val <= bp_en ? h2 : avg_val;
               end
               // Bias estimate uses untrimmed data so the result replaces
               if (go_null)
                  null_acc <= 32'sd0;
               else if ((state == ST_NULL) & sample_valid)
                  null_acc <= null_acc + $signed({{16{raw[15]}}, raw});
            end
         end
      end
   endgenerate

   // Filtered outputs straight from the axis output flops
   assign filt_x = g_axis[0].out_val;
   assign filt_y = g_axis[1].out_val;
   assign filt_z = g_axis[2].out_val;

endmodule // vsf_top

// File: sim/tb.sv
// Self-checking bench for the vibration filter and offset block
`timescale 1ns/1ps
module tb;
   reg ref_clk = 1'b0;
   reg sys_rst = 1'b1;
   reg sample_valid = 1'b0;
   reg [15:0] sample_x = 16'h0000;
   reg [15:0] sample_y = 16'h0000;
   reg [15:0] sample_z = 16'h0000;
   reg [15:0] buf_data = 16'ha000;
   wire spi_cs_n, spi_sclk, spi_mosi, spi_miso;
   wire buf_rd, capture_start, capture_manual, busy, filt_valid;
   wire [15:0] filt_x, filt_y, filt_z;
   integer fails = 0;
   integer tests_run = 0;
   integer cyc = 0;
   integer fcnt = 0;
   integer scnt = 0;
   integer i;
   reg [15:0] r;
   reg [15:0] q;
   reg [15:0] p;
   always #50 ref_clk = ~ref_clk;
   vsf_top #(.TEST_CYCLES(20), .PROD_CODE(16'h0a5c)) dut_u (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .sample_valid(sample_valid), .sample_x(sample_x),
      .sample_y(sample_y), .sample_z(sample_z), .buf_data(buf_data),
      .buf_rd(buf_rd), .capture_start(capture_start),
      .capture_manual(capture_manual), .busy(busy),
      .filt_valid(filt_valid), .filt_x(filt_x), .filt_y(filt_y),
      .filt_z(filt_z));
   vsf_spi_host host_u (.ref_clk(ref_clk), .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
   // ********
   // Tallies, buffer stand-in and hang guard
   // ********
   // The ceiling allows for the long null run plus slack
   always @(posedge ref_clk)
   begin
      cyc = cyc + 1;
      if (filt_valid === 1'b1) fcnt = fcnt + 1;
      if (capture_start === 1'b1) scnt = scnt + 1;
      if (cyc == 90000)
      begin
         fails = fails + 1;
         wrap_up;
      end
      if (buf_rd === 1'b1) #5 buf_data = buf_data + 16'h0101;
   end
   task chk(input [15:0] got, input [15:0] exp);
   begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // Even address takes the low byte, odd the high
   task wr(input [6:0] a, input [15:0] d);
   begin
      host_u.xfer({1'b1, a, d[7:0]}, 16, q);
      host_u.xfer({1'b1, a | 7'h01, d[15:8]}, 16, q);
   end
   endtask
   // Answer arrives one frame late, so a filler frame follows
   task rd(input [6:0] a, output [15:0] d);
   begin
      host_u.xfer({1'b0, a, 8'h00}, 16, q);
      host_u.xfer(16'h0000, 16, d);
   end
   endtask
   task smp(input [15:0] x, input [15:0] y, input [15:0] z);
   begin
      sample_x = x;
      sample_y = y;
      sample_z = z;
      sample_valid = 1'b1;
      @(posedge ref_clk);
      #5 sample_valid = 1'b0;
      repeat (2) @(posedge ref_clk);
      #5;
   end
   endtask
   task wait_idle;
      integer n;
   begin
      n = 0;
      while (busy !== 1'b0 && n < 2000)
      begin
         @(posedge ref_clk);
         #5 n = n + 1;
      end
      // A command that never finishes is a failure, not a skip
      if (n >= 2000)
      begin
         fails = fails + 1;
         wrap_up;
      end
   end
   endtask
   // ********
   // Scenarios
   // ********
   task t_regs;
   begin
      chk({15'h0000, capture_manual}, 16'h0001);
      for (i = 0; i < 3; i = i + 1)
      begin
         rd(7'h02 + {i[5:0], 1'b0}, r);
         chk(r, 16'h0000);
      end
      rd(7'h1c, r);
      chk(r, 16'h0000);
      rd(7'h38, r);
      chk(r, 16'h0000);
      host_u.xfer({1'b1, 7'h56, 8'hff}, 16, q);
      rd(7'h56, r);
      chk(r, 16'h0a5c);
      rd(7'h52, r);
      chk(r, 16'h1111);
      rd(7'h58, r);
      chk(r, 16'h0123);
   end
   endtask
   // Trim adds, saturates at the negative end, then block means
   task t_filt;
   begin
      wr(7'h02, 16'h00d2);
      wr(7'h04, 16'hffce);
      wr(7'h06, 16'hffff);
      smp(16'h03e8, 16'h0064, 16'h8000);
      chk(filt_x, 16'h04ba);
      chk(filt_y, 16'h0032);
      chk(filt_z, 16'h8000);
      wr(7'h38, 16'h0002);
      p = fcnt;
      smp(16'h000a, 16'h0001, 16'h0000);
      smp(16'h000b, 16'h0000, 16'h0000);
      smp(16'h000c, 16'h0000, 16'h0000);
      chk(fcnt - p, 16'h0000);
      smp(16'h000e, 16'h0000, 16'h0000);
      chk(fcnt - p, 16'h0001);
      chk(filt_x, 16'h00dd);
      chk(filt_y, 16'hffce);
      wr(7'h38, 16'h000f);
      rd(7'h38, r);
      chk(r, 16'h000f);
      p = fcnt;
      for (i = 0; i < 1024; i = i + 1)
         smp(i[15:0], 16'h0000, 16'h0000);
      chk(fcnt - p, 16'h0001);
      chk(filt_x, 16'h02d1);
   end
   endtask
   task t_band;
   begin
      wr(7'h38, 16'h0000);
      wr(7'h1c, 16'h0080);
      for (i = 0; i < 40; i = i + 1)
         smp(16'h03e8, 16'h0000, 16'h0000);
      chk({15'h0000, filt_x === 16'h04ba}, 16'h0000);
      wr(7'h1c, 16'h0000);
      smp(16'h03e8, 16'h0000, 16'h0000);
      chk(filt_x, 16'h04ba);
   end
   endtask
   task t_null;
   begin
      rd(7'h50, p);
      host_u.xfer(16'hbe01, 16, q);
      chk({15'h0000, busy}, 16'h0001);
      sample_x = 16'h0064;
      sample_y = 16'hffce;
      sample_z = 16'h0007;
      sample_valid = 1'b1;
      repeat (65536) @(posedge ref_clk);
      #5 sample_valid = 1'b0;
      wait_idle;
      rd(7'h02, r);
      chk(r, 16'hff9c);
      rd(7'h04, r);
      chk(r, 16'h0032);
      rd(7'h50, r);
      chk(r, p + 16'h0001);
   end
   endtask
   task t_diag;
   begin
      host_u.xfer(16'h1234, 8, q);
      rd(7'h3c, r);
      chk(r & 16'h0008, 16'h0008);
      host_u.xfer(16'hbe20, 16, q);
      chk({15'h0000, busy}, 16'h0001);
      wait_idle;
      rd(7'h3c, r);
      chk(r, 16'h0008);
      host_u.xfer(16'hbe10, 16, q);
      rd(7'h3c, r);
      chk(r, 16'h0000);
   end
   endtask
   task t_capt;
   begin
      p = scnt;
      host_u.xfer(16'hbf08, 16, q);
      chk(scnt - p, 16'h0001);
      host_u.xfer(16'h1400, 16, q);
      for (i = 0; i < 4; i = i + 1)
      begin
         host_u.xfer(16'h1400, 16, r);
         chk(r, 16'ha000 + 16'h0101 * i[15:0]);
      end
      host_u.xfer(16'h0000, 16, r);
      chk(r, 16'ha404);
   end
   endtask
   task wrap_up;
   begin
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk);
      #5 sys_rst = 1'b0;
      repeat (2) @(posedge ref_clk);
      #5;
      t_regs;
      t_filt;
      t_band;
      t_null;
      t_diag;
      t_capt;
      wrap_up;
   end
endmodule // tb

// File: sim/vsf_spi_host.sv
// Behavioural SPI host driving mode 3 register frames
`timescale 1ns/1ps
module vsf_spi_host (
   input wire ref_clk,
   output reg spi_cs_n,
   output reg spi_sclk,
   output reg spi_mosi,
   input wire spi_miso
);
   // ********
   // Frame engine
   // ********
   initial
   begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b1;
      spi_mosi = 1'b1;
   end
   // Three cycles a level so the block never misses an edge
   task xfer(input [15:0] tx, input integer nbits, output [15:0] rx);
      integer i;
   begin
      rx = 16'h0000;
      @(posedge ref_clk);
      #5 spi_cs_n = 1'b0;
      for (i = 15; i > 15 - nbits; i = i - 1)
      begin
         repeat (3) @(posedge ref_clk);
         #5 spi_sclk = 1'b0;
         spi_mosi = tx[i];
         repeat (3) @(posedge ref_clk);
         #5 spi_sclk = 1'b1;
         rx[i] = spi_miso;
      end
      repeat (3) @(posedge ref_clk);
      #5 spi_cs_n = 1'b1;
      // Released line shows the inverse, never a stale bit
      spi_mosi = ~spi_mosi;
      // Return off the edge so the caller never races the block
      repeat (6) @(posedge ref_clk);
      #5;
   end
   endtask
endmodule // vsf_spi_host

// File: sim/vsf_top_sva.sv
// Port checker for the vibration filter and offset block
`timescale 1ns/1ps
module vsf_top_sva (
   input wire ref_clk,
   input wire sys_rst,
   input wire spi_cs_n,
   input wire sample_valid,
   input wire buf_rd,
   input wire capture_start,
   input wire capture_manual,
   input wire busy,
   input wire filt_valid,
   input wire [15:0] filt_x
);
   // ********
   // Port relations
   // ********
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Frame effects land only after the settle cycles
   sequence quiet_two;
      (!capture_start && !buf_rd)[*2];
   endsequence
   sequence one_shot_start;
      spi_cs_n ##1 !capture_start;
   endsequence
   boot_manual_a:
      assert property ($fell(sys_rst) |-> ##2 capture_manual)
      else $error("manual mode missing after boot");
   boot_idle_a:
      assert property ($fell(sys_rst) |-> ##1 !busy)
      else $error("busy stuck after boot");
   manual_keep_a:
      assert property (!$fell(capture_manual) || $past(sys_rst))
      else $error("manual mode dropped");
   filt_cause_a:
      assert property (filt_valid |-> $past(sample_valid, 2))
      else $error("filter output without sample");
   filt_hold_a:
      assert property (!filt_valid && !$past(sys_rst) |-> $stable(filt_x))
      else $error("filter output moved between pulses");
   start_pulse_a:
      assert property (capture_start |-> one_shot_start)
      else $error("capture start not a single pulse");
   buf_pulse_a:
      assert property (buf_rd |-> spi_cs_n ##1 !buf_rd)
      else $error("buffer pop not a single pulse");
   frame_settle_a:
      assert property ($rose(spi_cs_n) |-> quiet_two)
      else $error("frame acted too early");
endmodule // vsf_top_sva

bind vsf_top vsf_top_sva chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .spi_cs_n(spi_cs_n), .sample_valid(sample_valid), .buf_rd(buf_rd),
   .capture_start(capture_start), .capture_manual(capture_manual),
   .busy(busy), .filt_valid(filt_valid), .filt_x(filt_x));
